/* mcd_dma.sv */
`timescale 1ns/1ps
module mcd_dma
  import mcd_pkg::*;
#(
  parameter int NCH = 32
)(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              cmd_valid,
  input  wire logic [CHAN_W-1:0] cmd_chan,
  input  wire logic              channel_tx_suspend_bit,
  input  wire logic              cmd_load,
  input  wire logic [31:0]       cmd_desc_addr,
  input  wire logic              slot_valid,
  input  wire logic [CHAN_W-1:0] slot_chan,
  input  wire logic [3:0]        slot_bits,
  output logic                   slot_ready,
  input  wire logic              rx_req,
  input  wire logic [CHAN_W-1:0] rx_chan,
  input  wire logic [31:0]       rx_desc_addr,
  output logic                   rx_ack,
  input  wire logic              rx_valid,
  input  wire logic [31:0]       rx_data,
  input  wire logic              rx_last,
  output logic                   rx_ready,
  output mcd_tx_out_s            tx_out,
  output mcd_bus_s               mem_bus,
  input  wire logic [31:0]       mem_rdata,
  input  wire logic              mem_wait
);

  function automatic logic [31:0] word_addr(input logic [31:0] base,
                                            input logic [15:0] idx);
    word_addr = base + {14'h0, idx, 2'b00};
  endfunction : word_addr

  mcd_state_e        st_r, st_nxt;
  logic [1:0]        step_r;
  logic [CHAN_W-1:0] ch_r, rxch_r;
  logic              pend_r;
  logic              bus_go, bus_we, bus_busy, bus_done;
  logic [31:0]       bus_addr, bus_wd;
  logic [31:0]       rx_desc_r, rx_next_r, rx_buf_r, intq_r;
  logic [15:0]       rx_size_r, rx_cnt_r, intq_idx_r;
  logic              rx_fe_r;

  logic              susp [NCH];
  logic              hold [NCH];
  logic              have [NCH];
  logic              fend [NCH];
  logic [FILL_W-1:0] fill [NCH];
  logic [7:0]        interframe_fill_count [NCH];
  logic [3:0]        acc  [NCH];
  logic [1:0]        oidx [NCH];
  logic [15:0]       wleft[NCH];
  logic [31:0]       cur  [NCH];
  logic [31:0]       nxt  [NCH];
  logic [31:0]       bufp [NCH];
  logic [31:0]       word [NCH];

  logic              slot_take, octet;
  logic [4:0]        acc_sum;
  logic [31:0]       int_word;

  assign slot_ready = st_r == ST_IDLE && !rx_req;
  assign slot_take  = slot_valid && slot_ready;
  assign rx_ack     = st_r == ST_IDLE && rx_req;
  assign acc_sum    = {1'b0, acc[slot_chan]} + {1'b0, slot_bits};
  assign octet      = acc_sum >= {1'b0, OCTET_BITS};
  assign rx_ready   = st_r == ST_RX_DATA && !bus_busy && !rx_fe_r &&
                      rx_cnt_r < rx_size_r;
  assign int_word   = (st_r == ST_RX_WB)
                    ? {1'b0, rx_fe_r, 25'h0, rxch_r}
                    : {1'b1, fend[ch_r], 25'h0, ch_r};

  always_comb begin
    st_nxt   = st_r;
    bus_go   = 1'b0;
    bus_we   = 1'b0;
    bus_addr = '0;
    bus_wd   = '0;
    case (st_r)
      ST_IDLE: begin
        if (rx_req) begin
          st_nxt = ST_RX_DESC;
        end else if (slot_take && !susp[slot_chan] &&
                     fill[slot_chan] == '0) begin
          if (!have[slot_chan] || hold[slot_chan]) begin
            st_nxt = ST_TX_DESC;
          end else if (octet && oidx[slot_chan] == 2'h0) begin
            st_nxt = ST_TX_DATA;
          end else if (octet && oidx[slot_chan] == 2'h3 &&
                       wleft[slot_chan] == '0) begin
            st_nxt = ST_TX_WB;
          end
        end
      end
      ST_RX_DESC: begin
        bus_go   = !bus_busy;
        bus_addr = word_addr(rx_desc_r, {14'h0, step_r});
        if (bus_done && step_r == RXW_SIZE) begin
          st_nxt = (mem_rdata[15:0] == '0) ? ST_RX_WB : ST_RX_DATA;
        end
      end
      ST_RX_DATA: begin
        bus_go   = rx_valid && rx_ready;
        bus_we   = 1'b1;
        bus_addr = word_addr(rx_buf_r, rx_cnt_r);
        bus_wd   = rx_data;
        if (bus_done && (rx_fe_r || rx_cnt_r + 16'h1 == rx_size_r)) begin
          st_nxt = ST_RX_WB;
        end
      end
      ST_RX_WB: begin
        bus_go = !bus_busy;
        bus_we = 1'b1;
        case (step_r)
          2'h0: begin
            bus_addr = RX_CDA_ADDR;
            bus_wd   = rx_desc_r;
          end
          2'h1: begin
            bus_addr = rx_desc_r + RX_STAT_OFS;
            bus_wd   = {rx_fe_r, 15'h0, rx_cnt_r};
          end
          default: begin
            bus_addr = intq_r;
            bus_wd   = int_word;
          end
        endcase
        if (bus_done && step_r == 2'h2) begin
          st_nxt = rx_fe_r ? ST_IDLE : ST_RX_DESC;
        end
      end
      ST_TX_DESC: begin
        bus_go   = !bus_busy;
        bus_addr = word_addr(cur[ch_r], {14'h0, step_r});
        if (bus_done && step_r == DW_CTRL && mem_rdata[TXC_HOLD]) begin
          st_nxt = ST_IDLE;
        end else if (bus_done && step_r == DW_NEXT) begin
          st_nxt = pend_r ? ST_TX_DATA : ST_IDLE;
        end
      end
      ST_TX_DATA: begin
        bus_go   = !bus_busy;
        bus_addr = bufp[ch_r];
        if (bus_done) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_TX_WB: begin
        bus_go = !bus_busy;
        bus_we = 1'b1;
        if (step_r == 2'h0) begin
          bus_addr = TX_CDA_BASE + {25'h0, ch_r, 2'b00};
          bus_wd   = cur[ch_r];
        end else begin
          bus_addr = intq_r;
          bus_wd   = int_word;
        end
        if (bus_done && step_r == 2'h1) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r   <= ST_IDLE;
      step_r <= 2'h0;
      ch_r   <= '0;
      pend_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (st_nxt != st_r) begin
        step_r <= 2'h0;
      end else if (bus_done) begin
        step_r <= step_r + 2'h1;
      end
      if (slot_take) begin
        ch_r   <= slot_chan;
        pend_r <= octet;
      end
    end
  end

  // The interrupt queue is a ring shared by both directions.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      intq_r     <= INTQ_BASE;
      intq_idx_r <= 16'h0;
    end else if (bus_done && bus_we && bus_addr == intq_r) begin
      if (intq_idx_r == INTQ_WORDS - 16'h1) begin
        intq_r     <= INTQ_BASE;
        intq_idx_r <= 16'h0;
      end else begin
        intq_r     <= intq_r + 32'h4;
        intq_idx_r <= intq_idx_r + 16'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_desc_r <= '0;
      rx_next_r <= '0;
      rx_buf_r  <= '0;
      rx_size_r <= '0;
      rx_cnt_r  <= '0;
      rx_fe_r   <= 1'b0;
      rxch_r    <= '0;
    end else begin
      if (rx_ack) begin
        rx_desc_r <= rx_desc_addr;
        rxch_r    <= rx_chan;
        rx_fe_r   <= 1'b0;
      end
      if (st_r == ST_RX_DESC && bus_done) begin
        case (step_r)
          RXW_NEXT: rx_next_r <= mem_rdata;
          RXW_BUF:  rx_buf_r  <= mem_rdata;
          default: begin
            rx_size_r <= mem_rdata[15:0];
            rx_cnt_r  <= 16'h0;
          end
        endcase
      end
      if (rx_valid && rx_ready) begin
        rx_fe_r <= rx_last;
      end
      if (st_r == ST_RX_DATA && bus_done) begin
        rx_cnt_r <= rx_cnt_r + 16'h1;
      end
      if (st_r == ST_RX_WB && bus_done && step_r == 2'h2 && !rx_fe_r) begin
        rx_desc_r <= rx_next_r;
      end
    end
  end

  // Per-channel transmit context, indexed by the slot, the latched or the command channel.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        susp[i]  <= 1'b0;
        hold[i]  <= 1'b0;
        have[i]  <= 1'b0;
        fend[i]  <= 1'b0;
        fill[i]  <= '0;
        interframe_fill_count[i]  <= '0;
        acc[i]   <= '0;
        oidx[i]  <= '0;
        wleft[i] <= '0;
        cur[i]   <= '0;
        nxt[i]   <= '0;
        bufp[i]  <= '0;
        word[i]  <= '0;
      end
    end else begin
      if (slot_take && !susp[slot_chan]) begin
        acc[slot_chan] <= octet ? 4'(acc_sum - 5'(OCTET_BITS))
                                : acc_sum[3:0];
        if (fill[slot_chan] != '0) begin
          if (octet) begin
            fill[slot_chan] <= fill[slot_chan] - FILL_W'(1);
          end
        end else if (have[slot_chan] && !hold[slot_chan] && octet &&
                     oidx[slot_chan] != 2'h0) begin
          oidx[slot_chan] <= oidx[slot_chan] + 2'h1;
        end
      end
      if (st_r == ST_TX_DESC && bus_done) begin
        case (step_r)
          DW_CTRL: begin
            hold[ch_r]  <= mem_rdata[TXC_HOLD];
            fend[ch_r]  <= mem_rdata[TXC_FEND];
            interframe_fill_count[ch_r]  <= mem_rdata[TXC_FILL_LSB +: 8];
            wleft[ch_r] <= mem_rdata[TXC_LEN_LSB +: 16];
            oidx[ch_r]  <= 2'h0;
          end
          DW_BUF:  bufp[ch_r] <= mem_rdata;
          default: begin
            nxt[ch_r]  <= mem_rdata;
            have[ch_r] <= 1'b1;
          end
        endcase
      end
      if (st_r == ST_TX_DATA && bus_done) begin
        word[ch_r]  <= mem_rdata;
        oidx[ch_r]  <= 2'h1;
        bufp[ch_r]  <= bufp[ch_r] + 32'h4;
        wleft[ch_r] <= wleft[ch_r] - 16'h1;
      end
      if (st_r == ST_TX_WB && bus_done && step_r == 2'h1) begin
        have[ch_r] <= 1'b0;
        cur[ch_r]  <= nxt[ch_r];
        fill[ch_r] <= (fend[ch_r] && interframe_fill_count[ch_r] != '0)
                    ? FILL_W'({1'b0, interframe_fill_count[ch_r]} + 9'h1) : '0;
      end
      if (cmd_valid) begin
        susp[cmd_chan] <= channel_tx_suspend_bit;
        if (cmd_load) begin
          cur[cmd_chan]  <= cmd_desc_addr;
          have[cmd_chan] <= 1'b0;
          fill[cmd_chan] <= '0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_out <= '0;
    end else begin
      tx_out <= '0;
      if (slot_take && !susp[slot_chan] && octet) begin
        if (fill[slot_chan] != '0) begin
          tx_out <= '{valid: 1'b1, fill: 1'b1, chan: slot_chan,
                      octet: IDLE_OCTET};
        end else if (have[slot_chan] && !hold[slot_chan] &&
                     oidx[slot_chan] != 2'h0) begin
          tx_out <= '{valid: 1'b1, fill: 1'b0, chan: slot_chan,
                      octet: word[slot_chan][8*oidx[slot_chan] +: 8]};
        end
      end else if (st_r == ST_TX_DATA && bus_done) begin
        tx_out <= '{valid: 1'b1, fill: 1'b0, chan: ch_r,
                    octet: mem_rdata[7:0]};
      end
    end
  end

  mcd_buscyc u_bus (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .start    (bus_go),
    .we       (bus_we),
    .addr     (bus_addr),
    .wdata    (bus_wd),
    .mem_wait (mem_wait),
    .bus      (mem_bus),
    .busy     (bus_busy),
    .done     (bus_done)
  );

  sequence s_rx_fetch;
    (st_r == ST_RX_DESC && bus_done && !bus_we && step_r == 2'h2);
  endsequence
  sequence s_tx_wb_end;
    (st_r == ST_TX_WB && bus_done && step_r == 2'h1);
  endsequence

  a_rx_fetch_reads: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(st_r == ST_RX_DATA) |-> $past(st_r) == ST_RX_DESC && $past(step_r) == 2'h2)
    else $error("receive data began before third descriptor read");
  a_rx_wb_three: assert property (@(posedge clk_sys) disable iff (rst)
    (st_r == ST_RX_WB && bus_done && step_r == 2'h2) |-> bus_we && mem_bus.addr == intq_r)
    else $error("receive write-back did not end with interrupt word");
  a_tx_wb_two: assert property (@(posedge clk_sys) disable iff (rst)
    s_tx_wb_end |=> st_r == ST_IDLE && !have[$past(ch_r)])
    else $error("transmit write-back did not end after two writes");
  a_suspend_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    (slot_take && susp[slot_chan]) |=> st_r == ST_IDLE && !tx_out.valid)
    else $error("suspended channel accessed memory");
  a_fill_no_poll: assert property (@(posedge clk_sys) disable iff (rst)
    (slot_take && !susp[slot_chan] && fill[slot_chan] != '0) |=> st_r == ST_IDLE)
    else $error("descriptor polled during idle fill");
  a_hold_one_read: assert property (@(posedge clk_sys) disable iff (rst)
    (st_r == ST_TX_DESC && bus_done && step_r == 2'h0 && mem_rdata[TXC_HOLD])
      |=> st_r == ST_IDLE ##1 !bus_busy)
    else $error("held descriptor read more than once per slot");
  a_data_per_word: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(st_r == ST_TX_DATA) && $past(st_r) == ST_IDLE |-> oidx[ch_r] == 2'h0)
    else $error("data word read before four octets were used");
  a_rx_ready_order: assert property (@(posedge clk_sys) disable iff (rst)
    rx_ready |-> st_r == ST_RX_DATA && !bus_busy && rx_cnt_r < rx_size_r)
    else $error("receive data accepted outside the data phase");
  a_rx_fetch_first: assert property (@(posedge clk_sys) disable iff (rst)
    s_rx_fetch |=> (st_r == ST_RX_DATA || st_r == ST_RX_WB) && !bus_busy)
    else $error("descriptor fetch not followed by data or write-back");

endmodule : mcd_dma

/* mcd_pkg.sv */
package mcd_pkg;

  localparam int          CHAN_W       = 5;
  localparam int          FILL_W       = 9;
  localparam int          BUS_MIN_CLKS = 4;
  // Descriptor word indices and the receive status word byte offset.
  localparam logic [1:0]  DW_CTRL      = 2'h0;
  localparam logic [1:0]  DW_BUF       = 2'h1;
  localparam logic [1:0]  DW_NEXT      = 2'h2;
  localparam logic [31:0] RX_STAT_OFS  = 32'h0000_000C;
  // Receive descriptor word 0 is the next pointer, word 1 the buffer.
  localparam logic [1:0]  RXW_NEXT     = 2'h0;
  localparam logic [1:0]  RXW_BUF      = 2'h1;
  localparam logic [1:0]  RXW_SIZE     = 2'h2;
  // Transmit control word fields.
  localparam int          TXC_HOLD     = 31;
  localparam int          TXC_FEND     = 30;
  localparam int          TXC_FILL_LSB = 16;
  localparam int          TXC_LEN_LSB  = 0;
  // Status and interrupt word fields.
  localparam int          ST_FEND      = 31;
  localparam int          IW_DIR       = 31;
  localparam int          IW_FEND      = 30;
  // Shared memory locations for write-back, the queue length, the idle octet and the bits per octet.
  localparam logic [31:0] RX_CDA_ADDR  = 32'h0000_0100;
  localparam logic [31:0] TX_CDA_BASE  = 32'h0000_0200;
  localparam logic [31:0] INTQ_BASE    = 32'h0000_0400;
  localparam logic [15:0] INTQ_WORDS   = 16'h0010;
  localparam logic [7:0]  IDLE_OCTET   = 8'h7E;
  localparam logic [3:0]  OCTET_BITS   = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RX_DESC, ST_RX_DATA, ST_RX_WB,
    ST_TX_DESC, ST_TX_DATA, ST_TX_WB
  } mcd_state_e;

  typedef struct packed {
    logic              valid;
    logic              fill;
    logic [CHAN_W-1:0] chan;
    logic [7:0]        octet;
  } mcd_tx_out_s;

  typedef struct packed {
    logic        cyc;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mcd_bus_s;

endpackage : mcd_pkg

/* mcd_buscyc.sv */
`timescale 1ns/1ps
module mcd_buscyc
  import mcd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic        we,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        mem_wait,
  output mcd_bus_s         bus,
  output logic             busy,
  output logic             done
);

  logic [1:0] phase_r;

  // Phase 2 stretches one clock per wait state.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_r <= 2'h0;
      bus     <= '0;
    end else if (start && !busy) begin
      phase_r <= 2'h0;
      bus     <= '{cyc: 1'b1, we: we, addr: addr, wdata: wdata};
    end else if (bus.cyc) begin
      if (done) begin
        bus.cyc <= 1'b0;
      end else if (!(phase_r == 2'h2 && mem_wait)) begin
        phase_r <= phase_r + 2'h1;
      end
    end
  end

  assign busy = bus.cyc;
  assign done = bus.cyc && phase_r == 2'(BUS_MIN_CLKS - 1);

  a_zero_wait: assert property (@(posedge clk_sys) disable iff (rst)
    (start && !busy) ##3 !mem_wait |=> done)
    else $error("bus cycle without wait not four clocks");
  a_wait_stretch: assert property (@(posedge clk_sys) disable iff (rst)
    (busy && phase_r == 2'h2 && mem_wait) |=> !done ##1 busy)
    else $error("wait state did not stretch bus cycle");

endmodule : mcd_buscyc

/* mcd_mem.sv */
`timescale 1ns/1ps
module mcd_mem
  import mcd_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  mcd_bus_s        mem_bus,
  input  wire logic [1:0] wait_n,
  output logic [31:0]     mem_rdata,
  output logic            mem_wait
);
  logic [31:0] mem [0:4095];
  logic [31:0] last_r;
  mcd_bus_s    op_r;
  logic [1:0]  phase_r;
  logic [1:0]  wcnt_r;
  int          len_r;
  logic [31:0] q_addr[$];
  logic        q_we[$];
  int          q_len[$];

  // Slow memory stalls in the third cycle of an operation.
  assign mem_wait = mem_bus.cyc && phase_r == 2'h2 && wcnt_r < wait_n;
  // Idle data lines show the inverse, so a stale word is never reused.
  assign mem_rdata = mem_bus.cyc ? mem[mem_bus.addr[13:2]] : ~last_r;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_r <= 2'h0;
      wcnt_r  <= 2'h0;
      len_r   <= 0;
      last_r  <= 32'h0000_0000;
    end else if (mem_bus.cyc) begin
      op_r   <= mem_bus;
      len_r  <= len_r + 1;
      last_r <= mem_rdata;
      if (mem_wait) begin
        wcnt_r <= wcnt_r + 2'h1;
      end else if (phase_r != 2'h3) begin
        phase_r <= phase_r + 2'h1;
      end
    end else begin
      if (len_r != 0) begin
        q_addr.push_back(op_r.addr);
        q_we.push_back(op_r.we);
        q_len.push_back(len_r);
        if (op_r.we) begin
          mem[op_r.addr[13:2]] <= op_r.wdata;
        end
      end
      phase_r <= 2'h0;
      wcnt_r  <= 2'h0;
      len_r   <= 0;
    end
  end
endmodule : mcd_mem

/* tb_mcd_dma.sv */
`timescale 1ns/1ps
module tb_mcd_dma;
  import mcd_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        cmd_valid = 1'b0;
  logic [4:0]  cmd_chan = 5'h00;
  logic        susp = 1'b0;
  logic        cmd_load = 1'b0;
  logic [31:0] cmd_desc_addr = 32'h0000_0000;
  logic        slot_valid = 1'b0;
  logic [3:0]  slot_bits = 4'h8;
  logic        slot_ready;
  logic        rx_req = 1'b0;
  logic [31:0] rx_desc_addr = 32'h0000_0000;
  logic        rx_ack;
  logic        rx_valid = 1'b0;
  logic [31:0] rx_data = 32'h0000_0000;
  logic        rx_last = 1'b0;
  logic        rx_ready;
  mcd_tx_out_s tx_out;
  mcd_bus_s    mem_bus;
  logic [31:0] mem_rdata;
  logic        mem_wait;
  logic [1:0]  wait_n = 2'h0;
  int          bad_count = 0;
  int          checks = 0;
  int          cda_w = 0;
  logic [8:0]  oq[$];
  logic [31:0] ea[$];
  logic        ew[$];
  logic [31:0] iq = INTQ_BASE;

  always #2 clk_sys = ~clk_sys;

  mcd_dma i_dut (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_chan(cmd_chan), .channel_tx_suspend_bit(susp), .cmd_load(cmd_load),
    .cmd_desc_addr(cmd_desc_addr), .slot_valid(slot_valid),
    .slot_chan(5'h03), .slot_bits(slot_bits), .slot_ready(slot_ready),
    .rx_req(rx_req), .rx_chan(5'h05), .rx_desc_addr(rx_desc_addr),
    .rx_ack(rx_ack), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_ready(rx_ready), .tx_out(tx_out),
    .mem_bus(mem_bus), .mem_rdata(mem_rdata), .mem_wait(mem_wait));

  mcd_mem i_mem (.clk_sys(clk_sys), .rst(rst), .mem_bus(mem_bus),
    .wait_n(wait_n), .mem_rdata(mem_rdata), .mem_wait(mem_wait));

  always @(posedge clk_sys) begin
    if (tx_out.valid === 1'b1) begin
      oq.push_back({tx_out.fill, tx_out.octet});
      chk(32'(tx_out.chan), 32'h0000_0003, "octet channel");
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string w);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, w, g, e);
    end
  endtask : chk

  task automatic chkn(input int g, input int e, input string w);
    checks++;
    if (g != e) begin
      bad_count++;
      $display("wrong value at %0t: %s got %0d expected %0d", $time, w, g, e);
    end
  endtask : chkn

  task automatic tick(inout int k, input string w);
    @(posedge clk_sys);
    k++;
    if (k > 3000) begin
      bad_count++;
      $display("wrong value at %0t: no answer to %s", $time, w);
      stop_test();
    end
  endtask : tick

  task automatic wait_idle();
    int k;
    k = 0;
    do tick(k, "idle"); while (!(slot_ready === 1'b1 && mem_bus.cyc === 1'b0));
    repeat (2) @(posedge clk_sys);
  endtask : wait_idle

  task automatic mw(input logic [31:0] a, input logic [31:0] d);
    i_mem.mem[a[13:2]] = d;
  endtask : mw

  function automatic logic [31:0] mr(input logic [31:0] a);
    return i_mem.mem[a[13:2]];
  endfunction : mr

  function automatic int nops(input logic [31:0] lo, input logic [31:0] hi,
                              input logic w);
    nops = 0;
    foreach (i_mem.q_addr[i]) begin
      if (i_mem.q_addr[i] >= lo && i_mem.q_addr[i] <= hi &&
          i_mem.q_we[i] === w) nops++;
    end
  endfunction : nops

  task automatic clr();
    cda_w += nops(TX_CDA_BASE + 32'h0000_000C, 32'h0000_020C, 1'b1);
    i_mem.q_addr.delete();
    i_mem.q_we.delete();
    i_mem.q_len.delete();
    oq.delete();
  endtask : clr

  task automatic ex(input logic [31:0] a, input logic w);
    ea.push_back(a);
    ew.push_back(w);
  endtask : ex

  task automatic ex_rx(input logic [31:0] d, input logic [31:0] b,
                       input int n);
    for (int i = 0; i < 3; i++) ex(d + 32'(4 * i), 1'b0);
    for (int i = 0; i < n; i++) ex(b + 32'(4 * i), 1'b1);
    ex(RX_CDA_ADDR, 1'b1);
    ex(d + RX_STAT_OFS, 1'b1);
    ex(iq, 1'b1);
    iq += 32'h0000_0004;
  endtask : ex_rx

  // Compares the logged operations, in full or as a prefix.
  task automatic chk_ops(input logic exact);
    if (exact) chkn(i_mem.q_addr.size(), ea.size(), "operation count");
    foreach (ea[i]) begin
      if (i < i_mem.q_addr.size()) begin
        chk(i_mem.q_addr[i], ea[i], "operation address");
        chk(32'(i_mem.q_we[i]), 32'(ew[i]), "direction");
        chkn(i_mem.q_len[i], 4 + wait_n, "operation length");
      end else begin
        chkn(i, -1, "missing operation");
      end
    end
    ea.delete();
    ew.delete();
  endtask : chk_ops

  task automatic rx_frame(input logic [31:0] d, input logic [31:0] b,
                          input int n);
    int k;
    @(posedge clk_sys);
    rx_req       <= 1'b1;
    rx_desc_addr <= d;
    k = 0;
    do tick(k, "receive request"); while (rx_ack !== 1'b1);
    rx_req <= 1'b0;
    for (int i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_data  <= b + 32'(i);
      rx_last  <= (i == n - 1);
      k = 0;
      do tick(k, "receive word"); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    wait_idle();
  endtask : rx_frame

  task automatic cmd(input logic s, input logic ld, input logic [31:0] a);
    @(posedge clk_sys);
    cmd_valid     <= 1'b1;
    cmd_chan      <= 5'h03;
    susp          <= s;
    cmd_load      <= ld;
    cmd_desc_addr <= a;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_load  <= 1'b0;
  endtask : cmd

  task automatic slots(input int n, input logic [3:0] b);
    int k;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      slot_valid <= 1'b1;
      slot_bits  <= b;
      k = 0;
      do tick(k, "slot"); while (slot_ready !== 1'b1);
      slot_valid <= 1'b0;
      wait_idle();
    end
  endtask : slots

  task automatic test_rx();
    wait_n <= 2'h1;
    mw(32'h0000_1000, 32'h0000_1100);
    mw(32'h0000_1004, 32'h0000_2000);
    mw(32'h0000_1008, 32'h0000_0002);
    clr();
    rx_frame(32'h0000_1000, 32'hA0A0_0000, 2);
    ex_rx(32'h0000_1000, 32'h0000_2000, 2);
    chk_ops(1'b1);
    chk(mr(32'h0000_2004), 32'hA0A0_0001, "buffer word");
    chk(mr(RX_CDA_ADDR), 32'h0000_1000, "descriptor address");
    chk(mr(32'h0000_100C), 32'h8000_0002, "status");
    chk(mr(iq - 32'h0000_0004), 32'h4000_0005, "interrupt");
    $display("test rx done");
  endtask : test_rx

  task automatic test_rx_chain();
    wait_n <= 2'h0;
    mw(32'h0000_1100, 32'h0000_1200);
    mw(32'h0000_1104, 32'h0000_2100);
    mw(32'h0000_1108, 32'h0000_0001);
    mw(32'h0000_1200, 32'h0000_0000);
    mw(32'h0000_1204, 32'h0000_2200);
    mw(32'h0000_1208, 32'h0000_0001);
    clr();
    rx_frame(32'h0000_1100, 32'hB0B0_0000, 2);
    ex_rx(32'h0000_1100, 32'h0000_2100, 1);
    ex_rx(32'h0000_1200, 32'h0000_2200, 1);
    chk_ops(1'b1);
    chk(mr(32'h0000_2200), 32'hB0B0_0001, "second buffer");
    chk(mr(32'h0000_110C), 32'h0000_0001, "open status");
    chk(mr(32'h0000_120C), 32'h8000_0001, "end status");
    $display("test rx chain done");
  endtask : test_rx_chain

  task automatic test_tx();
    mw(32'h0000_3000, 32'h4000_0001);
    mw(32'h0000_3004, 32'h0000_3400);
    mw(32'h0000_3008, 32'h0000_3100);
    mw(32'h0000_3400, 32'h4433_2211);
    mw(32'h0000_3100, 32'h4002_0001);
    mw(32'h0000_3104, 32'h0000_3500);
    mw(32'h0000_3108, 32'h0000_3200);
    mw(32'h0000_3500, 32'h8877_6655);
    mw(32'h0000_3200, 32'h8000_0000);
    mw(32'h0000_3204, 32'h0000_3600);
    mw(32'h0000_3208, 32'h0000_3300);
    mw(32'h0000_3600, 32'hDDCC_BBAA);
    mw(32'h0000_3300, 32'h8000_0000);
    clr();
    cmd(1'b0, 1'b1, 32'h0000_3000);
    slots(4, 4'h8);
    for (int i = 0; i < 4; i++) ex(32'h0000_3000 + 32'(4 * i), 1'b0);
    ea[3] = 32'h0000_3400;
    chk_ops(1'b0);
    chkn(nops(32'h0000_3400, 32'h0000_3400, 1'b0), 1, "data reads");
    chkn(oq.size(), 4, "octets");
    foreach (oq[i]) chk(32'(oq[i]), 32'(8'h11 * (i + 1)), "octet");
    $display("test tx done");
  endtask : test_tx

  task automatic test_fill();
    clr();
    slots(7, 4'h8);
    chkn(oq.size(), 7, "octets and fill");
    for (int i = 0; i < 7; i++) begin
      chk(32'(oq[i]), (i < 4) ? 32'(8'h55 + 8'h11 * i) : 32'h0000_017E,
          "fill octet");
    end
    chkn(nops(32'h0000_3200, 32'h0000_320B, 1'b0), 0, "poll in fill");
    chkn(nops(32'h0000_3000, 32'h0000_3FFF, 1'b1), 0, "tx status");
    $display("test fill done");
  endtask : test_fill

  task automatic test_hold();
    clr();
    slots(2, 4'h8);
    chkn(nops(32'h0000_3200, 32'h0000_3200, 1'b0), 2, "hold polls");
    chkn(oq.size(), 0, "held octets");
    mw(32'h0000_3200, 32'h4000_0001);
    clr();
    slots(1, 4'h8);
    chkn(oq.size(), 1, "resumed octets");
    chk(32'(oq[0]), 32'h0000_00AA, "resumed octet");
    $display("test hold done");
  endtask : test_hold

  task automatic test_suspend();
    cmd(1'b1, 1'b0, 32'h0000_0000);
    clr();
    slots(3, 4'h8);
    chkn(i_mem.q_addr.size(), 0, "suspended accesses");
    chkn(oq.size(), 0, "suspended octets");
    cmd(1'b0, 1'b0, 32'h0000_0000);
    clr();
    slots(1, 4'h4);
    chkn(oq.size(), 0, "half octet");
    slots(1, 4'h4);
    chkn(oq.size(), 1, "whole octet");
    chk(32'(oq[0]), 32'h0000_00BB, "restart octet");
    clr();
    chkn(cda_w, 2, "tx descriptor writes");
    $display("test suspend done");
  endtask : test_suspend

  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    test_rx();
    test_rx_chain();
    test_tx();
    test_fill();
    test_hold();
    test_suspend();
    stop_test();
  end
endmodule : tb_mcd_dma
